/* File: hw/ps_cfg_defs.svh */
// Constants for the passive serial configuration target: timing, offsets, fields
`ifndef PS_CFG_DEFS_SVH
`define PS_CFG_DEFS_SVH

`define CLK_PERIOD_NS        8
`define POR_LONG_MS          100
`define POR_SHORT_MS         12
`define POR_LONG_CYC         ((`POR_LONG_MS * 1000000) / `CLK_PERIOD_NS)
`define POR_SHORT_CYC        ((`POR_SHORT_MS * 1000000) / `CLK_PERIOD_NS)
`define OSC_MHZ              10
`define OSC_DIV              ((1000 / `OSC_MHZ) / `CLK_PERIOD_NS)
`define SCLK_MAX_PERIOD_NS   10
`define DONE_TO_UCLK_MULT    4
`define DONE_TO_UCLK_CYC     ((`DONE_TO_UCLK_MULT * `SCLK_MAX_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTART_TIMEOUT_US   100
`define RESTART_CYC          ((`RESTART_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define USER_INIT_CYCLES     299
`define OSC_INIT_CYCLES      299

`define REG_CTRL             8'h00
`define REG_LENGTH           8'h04
`define REG_CHECK            8'h08
`define REG_STATUS           8'h0C
`define REG_RXWORD           8'h10
`define REG_BITCNT           8'h14

`define CTRL_USE_UCLK        0
`define CTRL_AUTO_RESTART    1
`define CTRL_RST             2'h0
`define LENGTH_RST           32'h00000020
`define CHECK_RST            32'h00000000
`define STATUS_ERR_BIT       4

`endif

/* File: hw/ps_cfg_pkg.sv */
// Types for the passive serial configuration target
package ps_cfg_pkg;

  typedef enum logic [3:0] {
    ST_POR,
    ST_RESET,
    ST_RELEASE,
    ST_CONFIG,
    ST_DONE_WAIT,
    ST_INIT_DELAY,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } stage_t;

endpackage

/* File: hw/edge_sync.sv */
// Two-stage synchroniser with rising edge detect for a group of pins
`timescale 1ns/1ps
`default_nettype none

module edge_sync #(
  parameter int unsigned    W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST;
      sync_q <= RST;
      prev_q <= RST;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign lvl_o  = sync_q;
  assign rise_o = sync_q & ~prev_q;

endmodule // edge_sync

`default_nettype wire

/* File: hw/passive_serial_config_target.sv */
// Passive serial configuration target: staging, serial intake, open-drain handshakes
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ps_cfg_defs.svh"

module passive_serial_config_target
  import ps_cfg_pkg::*;
#(
  parameter int unsigned POR_LONG_CYC    = `POR_LONG_CYC,
  parameter int unsigned POR_SHORT_CYC   = `POR_SHORT_CYC,
  parameter int unsigned RESTART_CYC     = `RESTART_CYC,
  parameter int unsigned OSC_INIT_CYCLES = `OSC_INIT_CYCLES,
  parameter int unsigned CNT_W           = 24
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        config_request_n,
  input  wire logic        status_n_i,
  output logic             status_n_o,
  output logic             status_n_oe,
  input  wire logic        config_done_i,
  output logic             config_done_o,
  output logic             config_done_oe,
  input  wire logic        serial_config_clock,
  input  wire logic        serial_config_data,
  input  wire logic        user_startup_clock,
  input  wire logic        por_delay_select,
  input  wire logic        io_pullup_enable_n,
  output logic             user_io_hiz,
  output logic             weak_pullup_en,
  output logic             user_mode
);

  localparam int unsigned OSC_DIV  = `OSC_DIV;
  localparam int unsigned D2U_CYC  = `DONE_TO_UCLK_CYC;
  localparam int unsigned UINIT    = `USER_INIT_CYCLES;

  function automatic logic [CNT_W-1:0] last_of(input int unsigned n);
    last_of = CNT_W'((n > 0) ? n - 1 : 0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  logic [7:0]       lvl;
  logic [7:0]       rise;
  logic             req_n_s;
  logic             stat_s;
  logic             done_s;
  logic             done_rise;
  logic             sclk_rise;
  logic             sdata_s;
  logic             uclk_rise;
  logic             por_sel_s;
  logic             pull_n_s;

  stage_t           state_q;
  stage_t           state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             start_q;
  logic             err_q;
  logic [31:0]      rx_q;
  logic [31:0]      bits_q;
  logic [31:0]      chk_q;
  logic [31:0]      word_in;
  logic             fold;
  logic             last_bit;
  logic [7:0]       osc_cnt_q;
  logic             osc_tick_q;
  logic             init_tick;
  logic [1:0]       ctrl_q;
  logic [31:0]      len_q;
  logic [31:0]      check_q;
  logic             wb_req;
  logic             wb_wr;

  // Pins arrive from outside the clock domain
  // synchronise all eight input pins
  edge_sync #(
    .W   (8),
    .RST (8'h03)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d_i    ({user_startup_clock, io_pullup_enable_n, por_delay_select, serial_config_data,
              serial_config_clock, config_done_i, status_n_i, config_request_n}),
    .lvl_o  (lvl),
    .rise_o (rise)
  );

  assign req_n_s   = lvl[0];
  assign stat_s    = lvl[1];
  assign done_s    = lvl[2];
  assign done_rise = rise[2];
  assign sclk_rise = rise[3];
  assign sdata_s   = lvl[4];
  assign por_sel_s = lvl[5];
  assign pull_n_s  = lvl[6];
  assign uclk_rise = rise[7];

  // Serial word as it stands after the bit now arriving
  assign word_in  = {rx_q[30:0], sdata_s};
  assign last_bit = (bits_q + 32'h00000001) == len_q;
  assign fold     = (bits_q[4:0] == 5'h1F) || last_bit;

  // user clock only counted in init
  assign init_tick = ctrl_q[`CTRL_USE_UCLK] ? uclk_rise : osc_tick_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_q  <= 8'h00;
      osc_tick_q <= 1'b0;
    end else begin
      osc_tick_q <= (osc_cnt_q == 8'(OSC_DIV - 1));
      osc_cnt_q  <= (osc_cnt_q == 8'(OSC_DIV - 1)) ? 8'h00 : osc_cnt_q + 8'h01;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    case (state_q)
      ST_POR: begin
        if (cnt_q == (por_sel_s ? last_of(POR_SHORT_CYC) : last_of(POR_LONG_CYC))) begin
          state_d = ST_RESET;
        end
      end
      ST_RESET: begin
        if (req_n_s && start_q) begin
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (stat_s) begin
          state_d = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (!stat_s) begin
          state_d = ST_ERROR;
        end else if (sclk_rise && last_bit) begin
          state_d = ((chk_q ^ word_in) == check_q) ? ST_DONE_WAIT : ST_ERROR;
        end
      end
      ST_DONE_WAIT: begin
        if (!stat_s) begin
          state_d = ST_ERROR;
        end else if (done_rise) begin
          state_d = ctrl_q[`CTRL_USE_UCLK] ? ST_INIT_DELAY : ST_INIT;
        end
      end
      ST_INIT_DELAY: begin
        if (cnt_q == last_of(D2U_CYC)) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        cnt_d = init_tick ? cnt_q + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q;
        if (init_tick && cnt_q == (ctrl_q[`CTRL_USE_UCLK] ? last_of(UINIT) : last_of(OSC_INIT_CYCLES))) begin
          state_d = ST_USER;
        end
      end
      ST_USER: begin
        cnt_d = cnt_q;
      end
      ST_ERROR: begin
        if (cnt_q == last_of(RESTART_CYC)) begin
          state_d = ctrl_q[`CTRL_AUTO_RESTART] ? ST_RELEASE : ST_RESET;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    if (state_q != ST_POR && !req_n_s) begin
      state_d = ST_RESET;
    end
    if (state_d != state_q) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_POR;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Armed by power-on end or a low request level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
    end else if (state_q == ST_POR && state_d == ST_RESET) begin
      start_q <= 1'b1;
    end else if (!req_n_s) begin
      start_q <= 1'b1;
    end else if (state_q == ST_RESET && state_d == ST_RELEASE) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q   <= 32'h00000000;
      bits_q <= 32'h00000000;
      chk_q  <= 32'h00000000;
    end else if (state_q == ST_RELEASE) begin
      bits_q <= 32'h00000000;
      chk_q  <= 32'h00000000;
    end else if (state_q == ST_CONFIG && sclk_rise) begin
      rx_q   <= word_in;
      bits_q <= bits_q + 32'h00000001;
      if (fold) begin
        chk_q <= chk_q ^ word_in;
      end
    end
  end

  // Sticky error, set wins over software clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 1'b0;
    end else if (state_d == ST_ERROR && state_q != ST_ERROR) begin
      err_q <= 1'b1;
    end else if (wb_wr && wb_adr_i == `REG_STATUS && wb_sel_i[0] && wb_dat_i[`STATUS_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // Pins follow the next stage so they switch with it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_n_o     <= 1'b0;
      status_n_oe    <= 1'b1;
      config_done_o  <= 1'b0;
      config_done_oe <= 1'b1;
      user_io_hiz    <= 1'b1;
      weak_pullup_en <= 1'b0;
      user_mode      <= 1'b0;
    end else begin
      status_n_o     <= 1'b0;
      status_n_oe    <= (state_d == ST_POR) || (state_d == ST_RESET) || (state_d == ST_ERROR);
      config_done_o  <= 1'b0;
      config_done_oe <= (state_d == ST_POR) || (state_d == ST_RESET) || (state_d == ST_RELEASE) ||
                        (state_d == ST_CONFIG) || (state_d == ST_ERROR);
      user_io_hiz    <= (state_d != ST_USER);
      weak_pullup_en <= !pull_n_s && (state_d != ST_POR) && (state_d != ST_USER);
      user_mode      <= (state_d == ST_USER);
    end
  end

  // Classic bus: one wait state, write lands on the ack edge
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_req && wb_we_i && wb_ack_o;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL:   wb_dat_o <= {30'h00000000, ctrl_q};
          `REG_LENGTH: wb_dat_o <= len_q;
          `REG_CHECK:  wb_dat_o <= check_q;
          `REG_STATUS: wb_dat_o <= {24'h000000, 3'h0, err_q, state_q};
          `REG_RXWORD: wb_dat_o <= rx_q;
          `REG_BITCNT: wb_dat_o <= bits_q;
          default:     wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Settings are written in any stage; length and check act in the configuration stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= `CTRL_RST;
      len_q   <= `LENGTH_RST;
      check_q <= `CHECK_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `REG_CTRL:   ctrl_q  <= wb_sel_i[0] ? wb_dat_i[1:0] : ctrl_q;
        `REG_LENGTH: len_q   <= merge(len_q, wb_dat_i, wb_sel_i);
        `REG_CHECK:  check_q <= merge(check_q, wb_dat_i, wb_sel_i);
        default:     ctrl_q  <= ctrl_q;
      endcase
    end
  end

endmodule // passive_serial_config_target

`default_nettype wire

/* File: test/ps_cfg_chk.sv */
// Port-level assertions for the configuration target
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic config_request_n,
  input wire logic status_n_i,
  input wire logic status_n_oe,
  input wire logic config_done_i,
  input wire logic config_done_oe,
  input wire logic io_pullup_enable_n,
  input wire logic user_io_hiz,
  input wire logic weak_pullup_en,
  input wire logic user_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Request pin passes two flops before it acts
  sequence req_low_s;
    !config_request_n [*6];
  endsequence
  bus_ack_a: assert property (bus_req_s |=> wb_ack_o)
    else $error("bus request not acknowledged");
  por_hold_a: assert property ($rose(arst_n) |-> (status_n_oe && user_io_hiz && !weak_pullup_en) [*8])
    else $error("power-on outputs not held");
  req_reset_a: assert property (req_low_s |-> status_n_oe && config_done_oe && user_io_hiz && !user_mode)
    else $error("request low without reset");
  status_rel_a: assert property ($fell(status_n_oe) |-> $past(config_request_n, 3))
    else $error("status released while request low");
  done_rel_a: assert property ($fell(config_done_oe) |-> status_n_i && !status_n_oe)
    else $error("done released outside configuration");
  user_out_a: assert property (user_mode |-> config_done_i && !user_io_hiz && !status_n_oe)
    else $error("user mode outputs wrong");
  user_init_a: assert property ($rose(user_mode) |-> $past(config_done_i, 300))
    else $error("user mode too soon after done");
  pullup_a: assert property (weak_pullup_en |-> !$past(io_pullup_enable_n, 3))
    else $error("pull-ups on while disabled");
endmodule // ps_cfg_chk
bind passive_serial_config_target ps_cfg_chk chk (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .config_request_n(config_request_n), .status_n_i(status_n_i), .status_n_oe(status_n_oe),
  .config_done_i(config_done_i), .config_done_oe(config_done_oe), .io_pullup_enable_n(io_pullup_enable_n),
  .user_io_hiz(user_io_hiz), .weak_pullup_en(weak_pullup_en), .user_mode(user_mode));
`default_nettype wire

/* File: test/cfg_memory_model.sv */
// Behavioural serial configuration memory
`timescale 1ns/1ps
`default_nettype none
module cfg_memory_model (
  input  wire logic        oe_sense,
  input  wire logic        cs_n,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic [63:0] image,
  output logic             oe_low,
  output logic             sclk,
  output logic             sdata
);
  // pull enable low, then let go
  assign oe_low = hold;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    forever begin
      // shift only when enabled and selected
      wait (oe_sense && !cs_n);
      if (slow) #2000;
      for (int i = 63; i >= 0; i--) begin
        sdata = image[i];
        #62.5 sclk = 1'b1;
        #62.5 sclk = 1'b0;
      end
      // Undriven line: never leave the last bit showing
      sdata = ~sdata;
      wait (!oe_sense || cs_n);
    end
  end
endmodule // cfg_memory_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the passive serial configuration target
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ps_cfg_pkg::*;
  logic        clk, arst_n, cyc, stb, we, ack, req_n, ucl, psel, pu_n, hold, slow;
  logic        st_o, st_oe, dn_o, dn_oe, sclk, sdat, hiz, wpu, umode, mem_low;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [63:0] image;
  int          fail_count, samples_checked, n, lo;
  time         t0;
  wire logic   st_line = !(st_oe || mem_low);
  wire logic   dn_line = !dn_oe;

  passive_serial_config_target #(.POR_LONG_CYC(200), .POR_SHORT_CYC(100), .RESTART_CYC(50)) dut (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .config_request_n(req_n),
    .status_n_i(st_line), .status_n_o(st_o), .status_n_oe(st_oe), .config_done_i(dn_line),
    .config_done_o(dn_o), .config_done_oe(dn_oe), .serial_config_clock(sclk), .serial_config_data(sdat),
    .user_startup_clock(ucl), .por_delay_select(psel), .io_pullup_enable_n(pu_n), .user_io_hiz(hiz),
    .weak_pullup_en(wpu), .user_mode(umode));
  cfg_memory_model mem (.oe_sense(st_line), .cs_n(dn_line), .hold(hold), .slow(slow), .image(image),
    .oe_low(mem_low), .sclk(sclk), .sdata(sdat));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] exp_sum(input logic [63:0] img);
    return img[63:32] ^ img[31:0];
  endfunction

  task automatic print_verdict;
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    fail_count++;
    $display("ERROR t=%0t wait limit reached", $time);
    print_verdict();
  endtask

  // Watched outputs: 0 status enable, 1 done enable, 2 user mode
  function automatic logic probe(input int w);
    case (w)
      0: probe = st_oe;
      1: probe = dn_oe;
      default: probe = umode;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic v, input int lim, output int k);
    k = 0;
    while (probe(w) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (probe(w) !== v) timeout();
  endtask

  // Classic cycle: hold everything until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) timeout();
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic uclk(input int k);
    repeat (k) begin
      ucl <= 1'b1;
      repeat (2) @(posedge clk);
      ucl <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic do_reset(input logic ps, input logic pu);
    arst_n <= 1'b0;
    psel <= ps;
    pu_n <= pu;
    hold <= 1'b1;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  initial begin
    {cyc, stb, we, adr, wdat, ucl, slow, image} = '0;
    sel = 4'hF;
    req_n = 1'b1;
    arst_n = 1'b0;
    void'($urandom(24));
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0], s[0]);
      @(posedge clk);
      check({st_oe, dn_oe, hiz, wpu}, 4'hE);
      check({st_o, dn_o}, 32'h0);
      wait_for(0, 1'b0, 400, n);
      lo = s ? 100 : 200;
      check(n >= lo && n <= lo + 12, 1'b1);
      check(wpu, !s[0]);
      $display("test power-on %0d done", s);
    end
    repeat (30) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[3:0], ST_RELEASE);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check(rd, i == 1 ? 32'h20 : 32'h0);
    end
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    image = {$urandom, $urandom};
    slow <= 1'($urandom);
    bus(1'b1, 8'h04, 32'h40);
    bus(1'b1, 8'h08, exp_sum(image));
    hold <= 1'b0;
    wait_for(1, 1'b0, 3000, n);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, image[31:0]);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h40);
    wait_for(2, 1'b1, 5000, n);
    check(n >= 3570 && n <= 3610, 1'b1);
    check(hiz, 1'b0);
    $display("test oscillator start done");
    bus(1'b1, 8'h00, 32'h1);
    // memory init request pulses the request line
    req_n <= 1'b0;
    repeat (8) @(posedge clk);
    check({st_oe, dn_oe, hiz, umode}, 4'hE);
    image = {$urandom, $urandom};
    bus(1'b1, 8'h08, exp_sum(image));
    req_n <= 1'b1;
    wait_for(0, 1'b0, 20, n);
    fork
      uclk(150);
      wait_for(1, 1'b0, 3000, n);
    join
    // pulse inside enable delay is not counted
    uclk(1);
    repeat (600) @(posedge clk);
    check(umode, 1'b0);
    uclk(298);
    repeat (20) @(posedge clk);
    check(umode, 1'b0);
    uclk(1);
    repeat (10) @(posedge clk);
    check(umode, 1'b1);
    $display("test user clock start done");
    bus(1'b1, 8'h00, 32'h2);
    bus(1'b1, 8'h08, ~exp_sum(image));
    req_n <= 1'b0;
    repeat (8) @(posedge clk);
    req_n <= 1'b1;
    wait_for(0, 1'b0, 20, n);
    wait_for(0, 1'b1, 3000, n);
    t0 = $time;
    bus(1'b1, 8'h08, exp_sum(image));
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[4], 1'b1);
    wait_for(0, 1'b0, 100, n);
    check(($time - t0) / 8 >= 50 && ($time - t0) / 8 <= 58, 1'b1);
    bus(1'b1, 8'h0C, 32'h10);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[4], 1'b0);
    wait_for(2, 1'b1, 6000, n);
    check(hiz, 1'b0);
    $display("test error restart done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
